/* hw/cpi_pkg.sv */
// shared constants and types for the controller port input block
package cpi_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    localparam logic [23:0] CPI_PIN_STATE_IDX    = 24'hDFF016;
    localparam logic [23:0] CPI_PORT_CTRL_IDX    = 24'hDFF034;
    localparam logic [23:0] CPI_PORT_ONE_CNT_IDX = 24'hDFF040;
    localparam logic [23:0] CPI_PORT_TWO_CNT_IDX = 24'hDFF042;
    localparam logic [23:0] CPI_BEAM_UPPER_IDX   = 24'hDFF044;
    localparam logic [23:0] CPI_BEAM_LOWER_IDX   = 24'hDFF046;
    localparam logic [23:0] CPI_DISP_CTRL_IDX    = 24'hDFF048;

    // ==========================================================
    // field positions
    localparam int          CPI_START_BIT   = 0;
    localparam int          CPI_PEN_EN_BIT  = 3;
    localparam int          CPI_PIN_OE_LSB  = 9;
    localparam int          CPI_PIN_DAT_LSB = 8;
    localparam int          CPI_NUM_PINS    = 4;

    // ==========================================================
    // reset values and identity codes (identity values are arbitrary)
    localparam logic [7:0]  CPI_CTRL_RST    = 8'h00;
    localparam logic [15:0] CPI_DISP_RST    = 16'h0000;
    localparam logic [6:0]  CPI_PORT_REV_ID = 7'h2A;
    localparam logic [13:0] CPI_CHIP_ID     = 14'h0155;

    // ==========================================================
    // timing counts in scan lines
    localparam logic [2:0]  CPI_DUMP_LINES  = 3'h7;
    localparam logic [8:0]  CPI_RELEASE_V   = 9'h014;

    // ==========================================================
    // types
    typedef enum logic [1:0]
    {
        CPI_IDLE  = 2'b00,
        CPI_DUMP  = 2'b01,
        CPI_COUNT = 2'b11
    } cpi_pot_state_t;

    typedef struct packed
    {
        logic       long_frame;
        logic [8:0] v;
        logic [8:0] h;
    } cpi_beam_t;

endpackage : cpi_pkg

/* hw/cpi_port_input.sv */
// controller port pot counters, pot pin port and light pen latch
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - each axis counter is eight bits and wraps silently past 255
// - analog count register: vertical count high byte, horizontal low byte
// - writing start bit one dumps capacitors, zeroes counters, starts new cycle
// - counters held about seven lines, then count per line below threshold
// - control written at one address, pin states read at another
// - four pin output-enable and data pairs in bits fifteen to eight
// - bits seven to one read a fixed revision value, writes ignored
// - enabled pin is driven to its data bit and leaves counting
// - non-enabled pins are inputs, readable and still feed counters
// - pen capture arms automatically as vertical blanking ends
// - pen trigger pulse captures horizontal and vertical beam counters
// - upper holds frame flag, chip id, V8; lower holds V7-V0, H8-H1
// - horizontal resolves two low-res pixels; vertical one line
// - pen input works only with display control bit three set
// - a trigger freezes the position registers until release
// - without trigger, position latches at end of display field
// - freeze released at end of internal blanking, line twenty
// - no status bit tells that a pen trigger happened
module cpi_port_input
    import cpi_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // wishbone slave
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [25:0]             adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    // video timing, same clock domain
    input  wire cpi_beam_t               beam_i,
    input  wire logic                    line_start_i,
    input  wire logic                    field_end_i,
    // pot pins: port one pin5, pin9, port two pin5, pin9
    input  wire logic [CPI_NUM_PINS-1:0] pot_pin_i,
    output logic      [CPI_NUM_PINS-1:0] pot_pin_o,
    output logic      [CPI_NUM_PINS-1:0] pot_pin_oe_o,
    // capacitor comparators and discharge
    input  wire logic [CPI_NUM_PINS-1:0] pot_above_i,
    output logic      [CPI_NUM_PINS-1:0] pot_dump_o,
    // light pen beam trigger, active low pin
    input  wire logic                    pen_trig_n_i
);

    // ==========================================================
    // address decode

    // true when the word address matches a register index
    function automatic logic cpi_hit(input logic [25:0] adr, input logic [23:0] idx);
        cpi_hit = (adr[25:2] == idx);
    endfunction : cpi_hit

    wire logic req      = cyc_i & stb_i;
    wire logic wr_go    = req & we_i & ack_o;
    wire logic hit_pin  = cpi_hit(adr_i, CPI_PIN_STATE_IDX);
    wire logic hit_ctrl = cpi_hit(adr_i, CPI_PORT_CTRL_IDX);
    wire logic hit_one  = cpi_hit(adr_i, CPI_PORT_ONE_CNT_IDX);
    wire logic hit_two  = cpi_hit(adr_i, CPI_PORT_TWO_CNT_IDX);
    wire logic hit_up   = cpi_hit(adr_i, CPI_BEAM_UPPER_IDX);
    wire logic hit_lo   = cpi_hit(adr_i, CPI_BEAM_LOWER_IDX);
    wire logic hit_disp = cpi_hit(adr_i, CPI_DISP_CTRL_IDX);

    // ==========================================================
    // pin synchronisers

    logic [CPI_NUM_PINS-1:0] pin_meta;
    logic [CPI_NUM_PINS-1:0] pin_sync;
    logic [CPI_NUM_PINS-1:0] above_meta;
    logic [CPI_NUM_PINS-1:0] above_sync;
    logic                    trig_meta;
    logic                    trig_sync;
    logic                    trig_prev;

    // two flops on every pot pin, comparator and pen trigger input before any logic reads it
    always_ff @(posedge clk_i)
    begin
        pin_meta   <= pot_pin_i;
        pin_sync   <= pin_meta;
        above_meta <= pot_above_i;
        above_sync <= above_meta;
        trig_meta  <= pen_trig_n_i;
        trig_sync  <= trig_meta;
        trig_prev  <= trig_sync;
    end

    // falling edge of the active-low trigger is one pulse
    wire logic trig_pulse = trig_prev & ~trig_sync;

    // ==========================================================
    // control registers

    logic [7:0]  ctrl;
    logic [15:0] disp_ctrl;

    wire logic start_wr = wr_go & hit_ctrl & sel_i[0] & dat_i[CPI_START_BIT];
    wire logic pen_en   = disp_ctrl[CPI_PEN_EN_BIT];

    // only the high byte of the port control is stored; low byte is a strobe
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl      <= CPI_CTRL_RST;
            disp_ctrl <= CPI_DISP_RST;
        end
        else
        begin
            if (wr_go && hit_ctrl && sel_i[1])
                ctrl <= dat_i[15:8];
            if (wr_go && hit_disp && sel_i[0])
                disp_ctrl[7:0] <= dat_i[7:0];
            if (wr_go && hit_disp && sel_i[1])
                disp_ctrl[15:8] <= dat_i[15:8];
        end
    end

    // ==========================================================
    // pin output drive

    logic [CPI_NUM_PINS-1:0] pin_oe;
    logic [CPI_NUM_PINS-1:0] pin_dat;

    genvar g;
    generate
        for (g = 0; g < CPI_NUM_PINS; g++)
        begin : g_pin_bits
            assign pin_oe[g]  = ctrl[CPI_PIN_OE_LSB - 8 + 2*g];
            assign pin_dat[g] = ctrl[CPI_PIN_DAT_LSB - 8 + 2*g];
        end
    endgenerate

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pot_pin_oe_o <= '0;
            pot_pin_o    <= '0;
        end
        else
        begin
            pot_pin_oe_o <= pin_oe;
            pot_pin_o    <= pin_dat;
        end
    end

    // ==========================================================
    // pot counting sequence

    cpi_pot_state_t          state;
    cpi_pot_state_t          next_state;
    logic [2:0]              dump_cnt;
    logic [7:0]              pot_cnt [CPI_NUM_PINS];

    wire logic dump_done = line_start_i && (dump_cnt == CPI_DUMP_LINES - 3'h1);

    // hold for the dump lines then count
    always_comb
    begin
        next_state = state;
        case (state)
            CPI_IDLE:  next_state = CPI_IDLE;
            CPI_DUMP:  next_state = dump_done ? CPI_COUNT : CPI_DUMP;
            CPI_COUNT: next_state = CPI_COUNT;
            default:   next_state = CPI_IDLE;
        endcase
        if (start_wr)
            next_state = CPI_DUMP;
    end

    // dump line counter runs only while discharging
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state    <= CPI_IDLE;
            dump_cnt <= 3'h0;
        end
        else
        begin
            state <= next_state;
            if (start_wr || state != CPI_DUMP || dump_done)
                dump_cnt <= 3'h0;
            else if (line_start_i)
                dump_cnt <= dump_cnt + 3'h1;
        end
    end

    // discharge only pins not driven, so an output pin stays disconnected
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pot_dump_o <= '0;
        else
            pot_dump_o <= (next_state == CPI_DUMP) ? ~pin_oe : '0;
    end

    // per axis counters; no overflow flag, capacitor sizing keeps a frame short of it
    generate
        for (g = 0; g < CPI_NUM_PINS; g++)
        begin : g_pot_cnt
            wire logic step = (state == CPI_COUNT) & line_start_i & ~above_sync[g] & ~pin_oe[g];
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    pot_cnt[g] <= 8'h00;
                // clear on start, held through the dump lines
                else if (start_wr || state == CPI_DUMP)
                    pot_cnt[g] <= 8'h00;
                else if (step)
                    pot_cnt[g] <= pot_cnt[g] + 8'h01;
            end
        end
    endgenerate

    // ==========================================================
    // light pen latch

    logic      armed;
    logic      frozen;
    cpi_beam_t pen_pos;

    wire logic release_line = line_start_i && (beam_i.v == CPI_RELEASE_V);
    // gated by display control bit three
    wire logic pen_capture  = pen_en & armed & ~frozen & trig_pulse;
    // field end latches when nothing triggered
    wire logic field_latch  = pen_en & ~frozen & field_end_i;

    // no trigger flag kept; software infers it from the position
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            armed   <= 1'b0;
            frozen  <= 1'b0;
            pen_pos <= '0;
        end
        // release and re-arm at line twenty
        else if (release_line)
        begin
            armed  <= 1'b1;
            frozen <= 1'b0;
        end
        else if (pen_capture || field_latch)
        begin
            frozen  <= 1'b1;
            armed   <= 1'b0;
            pen_pos <= beam_i;
        end
    end

    // frozen value hides the live beam
    wire cpi_beam_t shown = (pen_en && frozen) ? pen_pos : beam_i;

    // ==========================================================
    // read data

    logic [15:0] pin_state;

    // pin levels at data positions, enables read back
    generate
        for (g = 0; g < CPI_NUM_PINS; g++)
        begin : g_pin_read
            assign pin_state[CPI_PIN_OE_LSB + 2*g]  = pin_oe[g];
            assign pin_state[CPI_PIN_DAT_LSB + 2*g] = pin_sync[g];
        end
    endgenerate
    assign pin_state[7:0] = {CPI_PORT_REV_ID, 1'b0};

    wire logic [15:0] rd_one = {pot_cnt[1], pot_cnt[0]};
    wire logic [15:0] rd_two = {pot_cnt[3], pot_cnt[2]};
    wire logic [15:0] rd_up  = {shown.long_frame, CPI_CHIP_ID, shown.v[8]};
    // horizontal drops H0, two low-res pixels per step
    wire logic [15:0] rd_lo  = {shown.v[7:0], shown.h[8:1]};

    // control address is write only and reads as zero
    wire logic [15:0] rd_mux = hit_pin  ? pin_state :
                               hit_one  ? rd_one    :
                               hit_two  ? rd_two    :
                               hit_up   ? rd_up     :
                               hit_lo   ? rd_lo     :
                               hit_disp ? disp_ctrl : 16'h0000;

    // ==========================================================
    // bus answer: one wait state, ack for one cycle, unmapped reads zero

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_o <= req & ~ack_o;
            if (req && !ack_o)
                dat_o <= {16'h0000, we_i ? 16'h0000 : rd_mux};
        end
    end

    // ==========================================================
    // assertions

    sequence s_start_taken;
        start_wr;
    endsequence

    sequence s_counts_zero;
        (pot_cnt[0] == 8'h00) && (pot_cnt[1] == 8'h00) && (pot_cnt[2] == 8'h00) && (pot_cnt[3] == 8'h00);
    endsequence

    property p_start_clears;
        @(posedge clk_i) disable iff (rst_i)
        s_start_taken |=> s_counts_zero ##0 (state == CPI_DUMP);
    endproperty

    a_start_clears: assert property (p_start_clears)
        else $error("start write did not clear counters");

    a_dump_length: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == CPI_DUMP) && dump_done && !start_wr |=> (state == CPI_COUNT) && (dump_cnt == 3'h0))
        else $error("dump phase did not end after seven lines");

    a_count_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == CPI_COUNT) && line_start_i && !above_sync[2] && !pin_oe[2] && !start_wr
        |=> pot_cnt[2] == $past(pot_cnt[2]) + 8'h01)
        else $error("axis counter did not step by one");

    a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == CPI_COUNT) && above_sync[2] && !start_wr |=> $stable(pot_cnt[2]))
        else $error("counter moved above threshold");

    a_drive_nodump: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 ((pot_dump_o & pot_pin_oe_o) == '0) && (pot_pin_oe_o == $past(pin_oe)))
        else $error("driven pin touched by counting circuit");

    // revision bits on a pin state read
    a_rev_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !we_i && hit_pin && !ack_o |=> ack_o && (dat_o[7:1] == CPI_PORT_REV_ID))
        else $error("revision field wrong");

    // capture takes the beam of the trigger cycle
    a_pen_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        pen_capture && !release_line |=> frozen && (pen_pos == $past(beam_i)) ##1 (rd_lo == {pen_pos.v[7:0], pen_pos.h[8:1]} || !pen_en))
        else $error("pen trigger did not capture beam");

    a_freeze_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        frozen && !release_line |=> frozen && $stable(pen_pos))
        else $error("frozen position changed");

    a_field_latch: assert property (@(posedge clk_i) disable iff (rst_i)
        field_latch && !release_line |=> frozen)
        else $error("field end did not latch position");

    a_release_v20: assert property (@(posedge clk_i) disable iff (rst_i)
        release_line |=> !frozen && armed)
        else $error("freeze not released at line twenty");

    // bus ack is a single-cycle pulse
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

endmodule : cpi_port_input

`default_nettype wire

/* testbench/cpi_port_partner.sv */
// behavioural pots, buttons and light pen on the controller port pins
`timescale 1ns/10ps
`default_nettype none

module cpi_port_partner
    import cpi_pkg::*;
#(
    // lines of charge until each capacitor passes threshold, pin 3 down to 0
    parameter logic [35:0] CHARGE = {9'h005, 9'h104, 9'h0C8, 9'h003}
)
(
    // clock and video
    input  wire logic       clk_i,
    input  wire logic       line_start_i,
    input  wire cpi_beam_t  beam_i,
    // pin controls from the block
    input  wire logic [3:0] dump_i,
    input  wire logic [3:0] drive_i,
    input  wire logic [3:0] oe_i,
    // bench controls
    input  wire logic [3:0] press_i,
    input  wire logic       pen_on_i,
    // towards the block
    output logic      [3:0] pin_o,
    output logic      [3:0] above_o,
    output logic            trig_n_o
);
    logic [8:0] lines [4] = '{default: 9'h000};
    logic [2:0] low_cnt   = 3'h0;

    // =========
    // charge time: lines since dump release, capped so a slow pot never wraps
    always_ff @(posedge clk_i)
    begin
        for (int k = 0; k < 4; k++)
        begin
            if (dump_i[k] || oe_i[k])
                lines[k] <= 9'h000;
            else if (line_start_i && lines[k] != 9'h1FF)
                lines[k] <= lines[k] + 9'h001;
        end
    end

    // comparator and pin level; a pressed button grounds the pin
    always_comb
    begin
        for (int k = 0; k < 4; k++)
        begin
            above_o[k] = (lines[k] >= CHARGE[k*9 +: 9]);
            pin_o[k]   = ~press_i[k] & (drive_i[k] | ~oe_i[k]);
        end
    end

    // =========
    // pen sees the beam at line 25, dot 6, and pulls its trigger low four cycles
    always_ff @(posedge clk_i)
    begin
        if (pen_on_i && beam_i.v == 9'h019 && beam_i.h == 9'h006)
            low_cnt <= 3'h4;
        else if (low_cnt != 3'h0)
            low_cnt <= low_cnt - 3'h1;
    end
    assign trig_n_o = (low_cnt == 3'h0);

endmodule : cpi_port_partner
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the controller port input block
`timescale 1ns/10ps
`default_nettype none

module tb
    import cpi_pkg::*;
;
    // =========
    // stimulus and observed signals
    logic        clk_i        = 1'b0;
    logic        rst_i        = 1'b1;
    logic        cyc_i        = 1'b0;
    logic        stb_i        = 1'b0;
    logic        we_i         = 1'b0;
    logic [3:0]  sel_i        = 4'h0;
    logic [25:0] adr_i        = 26'h0000000;
    logic [31:0] dat_i        = 32'h00000000;
    cpi_beam_t   beam_i       = '{long_frame: 1'b1, v: 9'h000, h: 9'h000};
    logic        line_start_i = 1'b0;
    logic        field_end_i  = 1'b0;
    logic [3:0]  press        = 4'h5;
    logic        pen_on       = 1'b0;
    logic [31:0] dat_o, rd, rd2;
    logic        ack_o, pen_trig_n_i;
    logic [3:0]  pot_pin_i, pot_pin_o, pot_pin_oe_o, pot_above_i, pot_dump_o;
    logic [15:0] tbl [4]      = '{16'h0000, 16'hFF00, 16'hAA00, 16'h00FE};
    int          n_errors     = 0;
    int          n_tests      = 0;

    always #10 clk_i = ~clk_i;

    // free-running beam: 16 clocks a line, 40 lines a field, field end at 38
    always @(posedge clk_i)
    begin
        beam_i.h     <= (beam_i.h == 9'h00F) ? 9'h000 : beam_i.h + 9'h001;
        if (beam_i.h == 9'h00F)
            beam_i.v <= (beam_i.v == 9'h027) ? 9'h000 : beam_i.v + 9'h001;
        line_start_i <= (beam_i.h == 9'h00F);
        field_end_i  <= (beam_i.h == 9'h00F) && (beam_i.v == 9'h025);
    end

    cpi_port_input dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .beam_i(beam_i),
        .line_start_i(line_start_i), .field_end_i(field_end_i), .pot_pin_i(pot_pin_i),
        .pot_pin_o(pot_pin_o), .pot_pin_oe_o(pot_pin_oe_o), .pot_above_i(pot_above_i),
        .pot_dump_o(pot_dump_o), .pen_trig_n_i(pen_trig_n_i));

    cpi_port_partner far_side (.clk_i(clk_i), .line_start_i(line_start_i), .beam_i(beam_i),
        .dump_i(pot_dump_o), .drive_i(pot_pin_o), .oe_i(pot_pin_oe_o), .press_i(press),
        .pen_on_i(pen_on), .pin_o(pot_pin_i), .above_o(pot_above_i), .trig_n_o(pen_trig_n_i));

    // =========
    // verdict, the single place where the run ends
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one classic cycle; entered just after a rising edge
    task automatic bus(input logic wr, input logic [23:0] idx, input logic [15:0] wd, output logic [31:0] rdat);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        sel_i <= 4'h3;
        adr_i <= {idx, 2'b00};
        dat_i <= {16'h0000, wd};
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        sel_i <= 4'h0;
        if (ack_o !== 1'b1)
        begin
            n_errors++;
            end_sim();
        end
        @(posedge clk_i);
    endtask : bus

    // waits for n line pulses, bounded
    task automatic lines(input int n);
        int seen;
        seen = 0;
        for (int c = 0; c < 20000 && seen < n; c++)
        begin
            @(posedge clk_i);
            if (line_start_i === 1'b1)
                seen++;
        end
        if (seen < n)
        begin
            n_errors++;
            end_sim();
        end
    endtask : lines

    // waits until the beam is on line v, bounded
    task automatic at_line(input logic [8:0] v);
        int c;
        c = 0;
        do
        begin
            @(posedge clk_i);
            c++;
        end while (beam_i.v !== v && c < 1000);
        if (c >= 1000)
        begin
            n_errors++;
            end_sim();
        end
    endtask : at_line

    function automatic logic [31:0] nib(input logic [15:0] c, input int o);
        return {28'h0000000, c[o+6], c[o+4], c[o+2], c[o]};
    endfunction : nib

    // expected pin state word: oe bits, wire levels, revision
    function automatic logic [31:0] pins(input logic [15:0] c, input logic [3:0] p);
        logic [31:0] r;
        r = {24'h000000, CPI_PORT_REV_ID, 1'b0};
        for (int k = 0; k < 4; k++)
        begin
            r[9+2*k] = c[9+2*k];
            r[8+2*k] = ~p[k] & (c[8+2*k] | ~c[9+2*k]);
        end
        return r;
    endfunction : pins

    // =========
    // main sequence
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("reset_drive", 32'h0, {24'h0, pot_pin_oe_o, pot_dump_o});
        @(posedge clk_i);
        // pin port: all inputs, all driven high, all driven low, buttons on pins 0 and 2
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b1, CPI_PORT_CTRL_IDX, tbl[i], rd);
            repeat (4) @(posedge clk_i);
            bus(1'b0, CPI_PIN_STATE_IDX, 16'h0000, rd);
            chk("pin_state", pins(tbl[i], press), rd);
            chk("pin_oe", nib(tbl[i], 9), {28'h0, pot_pin_oe_o});
            chk("pin_drive", nib(tbl[i], 8) & nib(tbl[i], 9), {28'h0, pot_pin_o & pot_pin_oe_o});
            chk("no_dump", 32'h0, {28'h0, pot_dump_o});
        end
        bus(1'b0, CPI_PORT_CTRL_IDX, 16'h0000, rd);
        chk("ctrl_read", 32'h0, rd);
        bus(1'b0, 24'hDFF050, 16'h0000, rd);
        chk("unmapped", 32'h0, rd);
        // pot counting, start at frame top, pin 3 driven as output
        press <= 4'h0;
        at_line(9'h000);
        bus(1'b1, CPI_PORT_CTRL_IDX, 16'h8001, rd);
        @(negedge clk_i);
        chk("dump_on", 32'h7, {28'h0, pot_dump_o});
        lines(6);
        @(negedge clk_i);
        chk("dump_held", 32'h7, {28'h0, pot_dump_o});
        lines(1);
        @(posedge clk_i);
        @(negedge clk_i);
        chk("dump_off", 32'h0, {28'h0, pot_dump_o});
        lines(280);
        bus(1'b0, CPI_PORT_ONE_CNT_IDX, 16'h0000, rd);
        chk("port_one", 32'h0000C803, rd);
        bus(1'b0, CPI_PORT_TWO_CNT_IDX, 16'h0000, rd);
        chk("port_two", 32'h00000004, rd);
        bus(1'b1, CPI_PORT_CTRL_IDX, 16'h0001, rd);
        bus(1'b0, CPI_PORT_ONE_CNT_IDX, 16'h0000, rd);
        chk("restart", 32'h0, rd);
        // pen input off: trigger ignored, position runs
        pen_on <= 1'b1;
        at_line(9'h01A);
        bus(1'b0, CPI_BEAM_LOWER_IDX, 16'h0000, rd);
        bus(1'b0, CPI_BEAM_LOWER_IDX, 16'h0000, rd2);
        chk("pen_off_live", 32'h1, {31'h0, rd !== rd2});
        // pen on: field end freezes, line 20 re-arms, trigger at line 25 captures
        bus(1'b1, CPI_DISP_CTRL_IDX, 16'h0008, rd);
        // still on line 26 here: go round to line 26 of the next field
        at_line(9'h000);
        at_line(9'h01A);
        bus(1'b0, CPI_BEAM_LOWER_IDX, 16'h0000, rd);
        bus(1'b0, CPI_BEAM_UPPER_IDX, 16'h0000, rd2);
        // trigger reaches the latch three clocks after the pin falls: dot 9
        chk("pen_lower", 32'h00001904, rd);
        chk("pen_upper", {16'h0, 1'b1, CPI_CHIP_ID, 1'b0}, rd2);
        bus(1'b0, CPI_BEAM_LOWER_IDX, 16'h0000, rd2);
        chk("pen_frozen", rd, rd2);
        // no trigger: release at line 20, then latch at field end
        pen_on <= 1'b0;
        at_line(9'h015);
        bus(1'b0, CPI_BEAM_LOWER_IDX, 16'h0000, rd);
        bus(1'b0, CPI_BEAM_LOWER_IDX, 16'h0000, rd2);
        chk("released", 32'h1, {31'h0, rd !== rd2});
        at_line(9'h002);
        bus(1'b0, CPI_BEAM_LOWER_IDX, 16'h0000, rd);
        chk("field_latch", 32'h00002600, rd);
        end_sim();
    end

endmodule : tb
`default_nettype wire
